// *** rtl/adc_seq_pkg.sv ***
// Shared constants, types and helpers for the converter sequencer pair.
// Assumes a single 100 MHz clock shared by both ends of the link.
package adc_seq_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int NUM_CHAN = 4;
  localparam int DATA_W = 12;
  localparam int CHAN_W = 2;
  localparam int CNT_W = 11;
  localparam int BUF_DEPTH = 2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  // Conversion per channel, least time, rounded up
  localparam int CONV_TIME_NS = 1650;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  // Track time after a sequence, least time, rounded up
  localparam int ACQ_TIME_NS = 350;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  // Start spacing: 500 kSPS single channel, 130 kSPS all four
  localparam int START_PERIOD_1CH_NS = 2000;
  localparam int START_PERIOD_4CH_NS = 7693;
  localparam int START_1CH_CYCLES = (START_PERIOD_1CH_NS
                                     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_4CH_CYCLES = (START_PERIOD_4CH_NS
                                     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe widths driven by the host
  localparam int START_LOW_CYCLES = 2;
  localparam int READ_LOW_CYCLES = 3;
  localparam int WRITE_LOW_CYCLES = 2;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] ACQ_LOAD = CNT_W'(ACQ_CYCLES);
  localparam logic [CNT_W-1:0] START_1CH_LOAD = CNT_W'(START_1CH_CYCLES);
  localparam logic [CNT_W-1:0] START_4CH_LOAD = CNT_W'(START_4CH_CYCLES);
  localparam logic [CNT_W-1:0] START_LOW_LAST = CNT_W'(START_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] READ_LOW_LAST = CNT_W'(READ_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] WRITE_LOW_LAST = CNT_W'(WRITE_LOW_CYCLES - 1);

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [NUM_CHAN-1:0] MASK_ALL = 4'hF;
  localparam logic [NUM_CHAN-1:0] MASK_NONE = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_CONV = 2'b10
  } dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_WRITE = 5'b00010,
    H_START = 5'b00100,
    H_RUN   = 5'b01000,
    H_READ  = 5'b10000
  } host_state_t;

  // Lowest selected channel, which is the next one converted
  function automatic logic [CHAN_W-1:0] first_chan(
      input logic [NUM_CHAN-1:0] m);
    logic [CHAN_W-1:0] c;
    c = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (m[i]) begin
        c = CHAN_W'(i);
      end
    end
    return c;
  endfunction

endpackage

// *** rtl/adc_seq_if.sv ***
// Pin-level link between the converter end and the host end.
// Resolves the shared data bus from the two output enables.
interface adc_seq_if;
  logic conversion_start_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic hw_select;
  logic [adc_seq_pkg::NUM_CHAN-1:0] chan_pins;
  logic eoc_n;
  logic busy;
  logic [adc_seq_pkg::DATA_W-1:0] dev_data_out;
  logic dev_data_oe;
  logic [adc_seq_pkg::DATA_W-1:0] host_data_out;
  logic host_data_oe;
  logic [adc_seq_pkg::DATA_W-1:0] data;

  // Bus level; an undriven bus reads as zero
  assign data = dev_data_oe ? dev_data_out :
                (host_data_oe ? host_data_out : adc_seq_pkg::DATA_ZERO);

  modport device (
    input conversion_start_n, cs_n, rd_n, wr_n, hw_select, chan_pins, data,
    output eoc_n, busy, dev_data_out, dev_data_oe
  );

  modport host (
    output conversion_start_n, cs_n, rd_n, wr_n, hw_select, chan_pins,
    output host_data_out, host_data_oe,
    input eoc_n, busy, data
  );
endinterface

// *** rtl/adc_seq_device.sv ***
// Converter end: sequencer, result buffer and parallel read port.
// Assumes link pins are synchronous to clk and the host honours pacing.

module adc_seq_device (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Link to host
  adc_seq_if.device link,
  // Analog stand-in: channel i at bits [12*i +: 12]
  input wire logic [adc_seq_pkg::NUM_CHAN*adc_seq_pkg::DATA_W-1:0]
    sample_in,
  // Status
  output logic [adc_seq_pkg::NUM_CHAN-1:0] hold,
  output logic start_refused,
  output logic [adc_seq_pkg::NUM_CHAN-1:0] sel_mask
);

  // ************************************************************
  // Declarations
  // ************************************************************
  adc_seq_pkg::dev_state_t state_reg;
  logic start_prev_reg;
  logic rd_act_prev_reg;
  logic wr_prev_reg;
  logic [adc_seq_pkg::NUM_CHAN-1:0] sw_mask_reg;
  logic [adc_seq_pkg::NUM_CHAN-1:0] remain_reg;
  logic [adc_seq_pkg::NUM_CHAN-1:0] hold_reg;
  logic [adc_seq_pkg::NUM_CHAN-1:0] sel_mask_reg;
  logic [adc_seq_pkg::CNT_W-1:0] cnt_reg;
  logic [adc_seq_pkg::DATA_W-1:0] held_reg [adc_seq_pkg::NUM_CHAN];
  logic busy_reg;
  logic eoc_n_reg;
  logic refused_reg;
  logic [adc_seq_pkg::DATA_W-1:0] buf_mem_reg [adc_seq_pkg::BUF_DEPTH];
  logic buf_wr_ptr_reg;
  logic buf_rd_ptr_reg;
  logic [1:0] buf_count_reg;
  logic [adc_seq_pkg::DATA_W-1:0] data_out_reg;
  logic data_oe_reg;

  logic start_fall;
  logic [adc_seq_pkg::NUM_CHAN-1:0] chosen_mask;
  logic start_ok;
  logic [adc_seq_pkg::CHAN_W-1:0] cur_chan;
  logic [adc_seq_pkg::NUM_CHAN-1:0] remain_next;
  logic conv_done;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic rd_act;
  logic wr_fall;

  // ************************************************************
  // Decode of link strobes
  // ************************************************************
  // Edges taken from registered copies; pins are synchronous
  assign start_fall = start_prev_reg & ~link.conversion_start_n;
  assign rd_act = ~link.cs_n & ~link.rd_n;
  assign wr_fall = wr_prev_reg & ~link.wr_n & ~link.cs_n;
  // Pin strap or programmed set, picked live by the host
  assign chosen_mask = link.hw_select ? link.chan_pins
                                      : sw_mask_reg;
  // An empty selection would give a zero-length sequence
  assign start_ok = (state_reg == adc_seq_pkg::DEV_IDLE) && start_fall
                    && (chosen_mask != adc_seq_pkg::MASK_NONE);
  assign cur_chan = adc_seq_pkg::first_chan(remain_reg);
  assign remain_next = remain_reg
                       & ~(adc_seq_pkg::NUM_CHAN'(1) << cur_chan);
  assign conv_done = (state_reg == adc_seq_pkg::DEV_CONV)
                     && (cnt_reg == adc_seq_pkg::CONV_LAST);
  assign buf_in_valid = conv_done;
  assign buf_in_ready = (buf_count_reg != 2'(adc_seq_pkg::BUF_DEPTH));
  assign buf_out_valid = (buf_count_reg != 2'h0);
  assign buf_out_ready = rd_act & ~rd_act_prev_reg;

  // Edge history of the strobes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_prev_reg <= 1'b1;
      rd_act_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
    end else begin
      start_prev_reg <= link.conversion_start_n;
      rd_act_prev_reg <= rd_act;
      wr_prev_reg <= link.wr_n;
    end
  end

  // ************************************************************
  // Channel select register
  // ************************************************************
  // Writes land only while idle so a running sequence keeps its set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_mask_reg <= adc_seq_pkg::MASK_ALL;
    end else if (wr_fall && state_reg == adc_seq_pkg::DEV_IDLE) begin
      sw_mask_reg <= link.data[adc_seq_pkg::NUM_CHAN-1:0];
    end
  end

  // ************************************************************
  // Simultaneous sample capture
  // ************************************************************
  // Every channel latched on the same edge, selected or not
  genvar ch;
  generate
    for (ch = 0; ch < adc_seq_pkg::NUM_CHAN; ch++) begin : g_hold
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          held_reg[ch] <= adc_seq_pkg::DATA_ZERO;
        end else if (start_ok) begin
          held_reg[ch] <= sample_in[ch*adc_seq_pkg::DATA_W +:
                                    adc_seq_pkg::DATA_W];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Sequencer
  // ************************************************************
  // A finished word waits in place if the buffer is full, so a
  // slow reader stretches the sequence rather than losing data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= adc_seq_pkg::DEV_IDLE;
      remain_reg <= adc_seq_pkg::MASK_NONE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        adc_seq_pkg::DEV_IDLE: begin
          cnt_reg <= '0;
          if (start_ok) begin
            remain_reg <= chosen_mask;
            state_reg <= adc_seq_pkg::DEV_CONV;
          end
        end
        adc_seq_pkg::DEV_CONV: begin
          if (!conv_done) begin
            cnt_reg <= cnt_reg + 1'b1;
          end else if (buf_in_ready) begin
            cnt_reg <= '0;
            remain_reg <= remain_next;
            if (remain_next == adc_seq_pkg::MASK_NONE) begin
              state_reg <= adc_seq_pkg::DEV_IDLE;
            end
          end
        end
        default: begin
          state_reg <= adc_seq_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // Busy, end flag, hold lines and the selected set on show
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      eoc_n_reg <= 1'b1;
      hold_reg <= adc_seq_pkg::MASK_NONE;
      sel_mask_reg <= adc_seq_pkg::MASK_NONE;
    end else begin
      eoc_n_reg <= ~(buf_in_valid & buf_in_ready);
      if (start_ok) begin
        busy_reg <= 1'b1;
        hold_reg <= adc_seq_pkg::MASK_ALL;
        sel_mask_reg <= chosen_mask;
      end else if (buf_in_valid && buf_in_ready
                   && remain_next == adc_seq_pkg::MASK_NONE) begin
        busy_reg <= 1'b0;
        hold_reg <= adc_seq_pkg::MASK_NONE;
      end
    end
  end

  // Start while busy or with nothing selected is flagged, not run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= start_fall & ~start_ok;
    end
  end

  // ************************************************************
  // Two-entry result buffer
  // ************************************************************
  generate
    for (ch = 0; ch < adc_seq_pkg::BUF_DEPTH; ch++) begin : g_buf
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          buf_mem_reg[ch] <= adc_seq_pkg::DATA_ZERO;
        end else if (buf_in_valid && buf_in_ready
                     && buf_wr_ptr_reg == 1'(ch)) begin
          buf_mem_reg[ch] <= held_reg[cur_chan];
        end
      end
    end
  endgenerate

  // Pointers and fill level; order kept first in, first out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_count_reg <= 2'h0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
      end
      case ({buf_in_valid & buf_in_ready, buf_out_valid & buf_out_ready})
        2'b10: buf_count_reg <= buf_count_reg + 2'h1;
        2'b01: buf_count_reg <= buf_count_reg - 2'h1;
        default: buf_count_reg <= buf_count_reg;
      endcase
    end
  end

  // ************************************************************
  // Parallel read port
  // ************************************************************
  // One word per read; an empty buffer repeats the last word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_out_reg <= adc_seq_pkg::DATA_ZERO;
      data_oe_reg <= 1'b0;
    end else begin
      data_oe_reg <= rd_act;
      if (buf_out_valid && buf_out_ready) begin
        data_out_reg <= buf_mem_reg[buf_rd_ptr_reg];
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.eoc_n = eoc_n_reg;
  assign link.busy = busy_reg;
  assign link.dev_data_out = data_out_reg;
  assign link.dev_data_oe = data_oe_reg;
  assign hold = hold_reg;
  assign start_refused = refused_reg;
  assign sel_mask = sel_mask_reg;

endmodule // adc_seq_device

// *** rtl/adc_seq_host.sv ***
// Host end: configures the channel set, paces starts, reads words.
// Assumes the converter end shares clk; reads during the sequence.
module adc_seq_host (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Link to converter
  adc_seq_if.host link,
  // Configuration request, taken while ready
  input wire logic cfg_valid,
  input wire logic cfg_hw_select,
  input wire logic [adc_seq_pkg::NUM_CHAN-1:0] cfg_mask,
  // Start request, taken while ready
  input wire logic start_req,
  // Status and results
  output logic ready,
  output logic [adc_seq_pkg::DATA_W-1:0] result,
  output logic [adc_seq_pkg::CHAN_W-1:0] result_chan,
  output logic result_valid
);

  adc_seq_pkg::host_state_t state_reg;
  logic [adc_seq_pkg::CNT_W-1:0] tmr_reg;
  logic [adc_seq_pkg::CNT_W-1:0] acq_reg;
  logic [adc_seq_pkg::CNT_W-1:0] period_reg;
  logic [adc_seq_pkg::NUM_CHAN-1:0] plan_reg;
  logic [adc_seq_pkg::NUM_CHAN-1:0] remain_reg;
  logic hw_sel_reg;
  logic start_n_reg;
  logic cs_n_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  logic [adc_seq_pkg::DATA_W-1:0] wdata_reg;
  logic wdata_oe_reg;
  logic ready_reg;
  logic [adc_seq_pkg::DATA_W-1:0] result_reg;
  logic [adc_seq_pkg::CHAN_W-1:0] result_chan_reg;
  logic result_valid_reg;
  logic [adc_seq_pkg::CHAN_W-1:0] cur_chan;
  logic [adc_seq_pkg::NUM_CHAN-1:0] remain_next;
  logic can_go;

  assign cur_chan = adc_seq_pkg::first_chan(remain_reg);
  assign remain_next = remain_reg
                       & ~(adc_seq_pkg::NUM_CHAN'(1) << cur_chan);
  // Idle, so the last read is done, track time served, spacing met
  assign can_go = (state_reg == adc_seq_pkg::H_IDLE)
                  && (acq_reg == '0) && (period_reg == '0)
                  && !cfg_valid && !start_req;

  // ************************************************************
  // Pacing counters
  // ************************************************************
  // Full-set sequences use the slower spacing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acq_reg <= '0;
      period_reg <= '0;
    end else begin
      if (state_reg == adc_seq_pkg::H_READ && tmr_reg ==
          adc_seq_pkg::READ_LOW_LAST && remain_next == '0) begin
        acq_reg <= adc_seq_pkg::ACQ_LOAD;
      end else if (acq_reg != '0) begin
        acq_reg <= acq_reg - 1'b1;
      end
      if (ready_reg && start_req) begin
        period_reg <= (plan_reg == adc_seq_pkg::MASK_ALL)
                      ? adc_seq_pkg::START_4CH_LOAD
                      : adc_seq_pkg::START_1CH_LOAD;
      end else if (period_reg != '0) begin
        period_reg <= period_reg - 1'b1;
      end
    end
  end

  // ************************************************************
  // Link sequencer
  // ************************************************************
  // Starts only from idle, so never while the converter is busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= adc_seq_pkg::H_IDLE;
      tmr_reg <= '0;
      plan_reg <= adc_seq_pkg::MASK_ALL;
      remain_reg <= adc_seq_pkg::MASK_NONE;
      hw_sel_reg <= 1'b1;
      start_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      wdata_reg <= adc_seq_pkg::DATA_ZERO;
      wdata_oe_reg <= 1'b0;
      ready_reg <= 1'b0;
      result_reg <= adc_seq_pkg::DATA_ZERO;
      result_chan_reg <= '0;
      result_valid_reg <= 1'b0;
    end else begin
      result_valid_reg <= 1'b0;
      ready_reg <= can_go;
      tmr_reg <= tmr_reg + 1'b1;
      case (state_reg)
        adc_seq_pkg::H_IDLE: begin
          tmr_reg <= '0;
          if (ready_reg && cfg_valid) begin
            plan_reg <= cfg_mask;
            hw_sel_reg <= cfg_hw_select;
            ready_reg <= 1'b0;
            if (!cfg_hw_select) begin
              wdata_reg <= {8'h00, cfg_mask};
              wdata_oe_reg <= 1'b1;
              cs_n_reg <= 1'b0;
              wr_n_reg <= 1'b0;
              state_reg <= adc_seq_pkg::H_WRITE;
            end
          end else if (ready_reg && start_req) begin
            remain_reg <= plan_reg;
            start_n_reg <= 1'b0;
            ready_reg <= 1'b0;
            state_reg <= adc_seq_pkg::H_START;
          end
        end
        adc_seq_pkg::H_WRITE: begin
          if (tmr_reg == adc_seq_pkg::WRITE_LOW_LAST) begin
            cs_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            wdata_oe_reg <= 1'b0;
            state_reg <= adc_seq_pkg::H_IDLE;
          end
        end
        adc_seq_pkg::H_START: begin
          if (tmr_reg == adc_seq_pkg::START_LOW_LAST) begin
            start_n_reg <= 1'b1;
            state_reg <= adc_seq_pkg::H_RUN;
          end
        end
        adc_seq_pkg::H_RUN: begin
          tmr_reg <= '0;
          if (!link.eoc_n) begin
            cs_n_reg <= 1'b0;
            rd_n_reg <= 1'b0;
            state_reg <= adc_seq_pkg::H_READ;
          end
        end
        adc_seq_pkg::H_READ: begin
          if (tmr_reg == adc_seq_pkg::READ_LOW_LAST) begin
            result_reg <= link.data;
            result_chan_reg <= cur_chan;
            result_valid_reg <= 1'b1;
            remain_reg <= remain_next;
            cs_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            state_reg <= (remain_next == '0) ? adc_seq_pkg::H_IDLE
                                             : adc_seq_pkg::H_RUN;
          end
        end
        default: begin
          state_reg <= adc_seq_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.conversion_start_n = start_n_reg;
  assign link.cs_n = cs_n_reg;
  assign link.rd_n = rd_n_reg;
  assign link.wr_n = wr_n_reg;
  assign link.hw_select = hw_sel_reg;
  assign link.chan_pins = plan_reg;
  assign link.host_data_out = wdata_reg;
  assign link.host_data_oe = wdata_oe_reg;
  assign ready = ready_reg;
  assign result = result_reg;
  assign result_chan = result_chan_reg;
  assign result_valid = result_valid_reg;

endmodule // adc_seq_host

// *** bench/adc_seq_asserts.sv ***
// Concurrent checks on the pins between converter end and host end.
// Assumes the bench top instantiates it beside the shared link.
module adc_seq_asserts (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic hw_select,
  input wire logic [adc_seq_pkg::NUM_CHAN-1:0] chan_pins,
  input wire logic eoc_n,
  input wire logic busy,
  input wire logic [adc_seq_pkg::DATA_W-1:0] dev_data_out,
  input wire logic dev_data_oe,
  input wire logic host_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Sequences and properties
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // One channel slot: 165 edges to the next end flag
  sequence s_slot;
    ##1 (eoc_n throughout ##163 1'b1) ##1 !eoc_n;
  endsequence
  sequence s_take;
    $fell(conversion_start_n) && !busy && hw_select && chan_pins != 4'h0;
  endsequence

  property p_take;
    s_take |=> busy;
  endproperty
  property p_first;
    $rose(busy) |-> s_slot;
  endproperty
  property p_next;
    !eoc_n && busy |-> s_slot;
  endproperty
  property p_pulse;
    !eoc_n |=> eoc_n;
  endproperty
  property p_end;
    $fell(busy) |-> !eoc_n;
  endproperty
  property p_acq;
    $fell(busy) |-> conversion_start_n throughout ##35 1'b1;
  endproperty
  property p_no_restart;
    busy |-> !$fell(conversion_start_n);
  endproperty
  property p_read;
    !cs_n && !rd_n && ($past(cs_n) || $past(rd_n)) |=> dev_data_oe;
  endproperty
  property p_release;
    dev_data_oe && (cs_n || rd_n) |=> !dev_data_oe;
  endproperty
  // Word must not change under a host still sampling it
  property p_word_hold;
    dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_out);
  endproperty
  property p_one_driver;
    !(dev_data_oe && host_data_oe);
  endproperty

  // ************************************************************
  // Assertions
  // ************************************************************
  a_take: assert property (p_take)
    else $error("start not taken");
  a_first: assert property (p_first)
    else $error("first slot length off");
  a_next: assert property (p_next)
    else $error("next slot length off");
  a_pulse: assert property (p_pulse)
    else $error("end flag wider than one cycle");
  a_end: assert property (p_end)
    else $error("busy fell without last end flag");
  a_acq: assert property (p_acq)
    else $error("restart inside track time");
  a_no_restart: assert property (p_no_restart)
    else $error("start while busy");
  a_read: assert property (p_read)
    else $error("read not answered");
  a_release: assert property (p_release)
    else $error("bus not released");
  a_word_hold: assert property (p_word_hold)
    else $error("word moved during read");
  a_one_driver: assert property (p_one_driver)
    else $error("bus driven twice");
endmodule // adc_seq_asserts

// *** bench/simultaneous_sampling_adc_sequencer_tb.sv ***
// Bench top: both ends joined by the link, driven from the host side.
// Assumes one 100 MHz clock; inputs change on the falling edge.
module simultaneous_sampling_adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk;
  logic sys_rst = 1'b1;
  logic [47:0] sample_in = 48'h0000_0000_0000;
  logic cfg_valid = 1'b0;
  logic cfg_hw_select = 1'b1;
  logic [3:0] cfg_mask = 4'hF;
  logic start_req = 1'b0;
  logic ready, result_valid, start_refused;
  logic [11:0] result;
  logic [1:0] result_chan;
  logic [3:0] hold, sel_mask;
  int errors = 0;
  int num_checks = 0;
  // Mode bit above the channel set, one entry a sequence
  logic [4:0] tbl [5] = '{5'h1F, 5'h1A, 5'h05, 5'h08, 5'h11};

  adc_seq_if adc_seq_if_inst ();
  adc_seq_device adc_seq_device_inst (.clk(clk), .sys_rst(sys_rst),
    .link(adc_seq_if_inst.device), .sample_in(sample_in), .hold(hold),
    .start_refused(start_refused), .sel_mask(sel_mask));
  adc_seq_host adc_seq_host_inst (.clk(clk), .sys_rst(sys_rst),
    .link(adc_seq_if_inst.host), .cfg_valid(cfg_valid),
    .cfg_hw_select(cfg_hw_select), .cfg_mask(cfg_mask),
    .start_req(start_req), .ready(ready), .result(result),
    .result_chan(result_chan), .result_valid(result_valid));
  adc_seq_asserts adc_seq_asserts_inst (.clk(clk), .sys_rst(sys_rst),
    .conversion_start_n(adc_seq_if_inst.conversion_start_n),
    .cs_n(adc_seq_if_inst.cs_n), .rd_n(adc_seq_if_inst.rd_n),
    .hw_select(adc_seq_if_inst.hw_select),
    .chan_pins(adc_seq_if_inst.chan_pins), .eoc_n(adc_seq_if_inst.eoc_n),
    .busy(adc_seq_if_inst.busy), .dev_data_out(adc_seq_if_inst.dev_data_out),
    .dev_data_oe(adc_seq_if_inst.dev_data_oe),
    .host_data_oe(adc_seq_if_inst.host_data_oe));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Bounded wait; a host that never frees up shows as a mismatch
  task automatic wait_ready;
    for (int i = 0; i < 2000 && ready !== 1'b1; i++) @(negedge clk);
    chk({15'h0, ready}, 16'h0001);
  endtask

  task automatic run_seq(input logic hw, input logic [3:0] mask);
    int n, got, busy_cyc;
    logic [1:0] ch;
    n = $countones(mask);
    got = 0;
    busy_cyc = 0;
    ch = 2'h0;
    wait_ready();
    cfg_hw_select = hw;
    cfg_mask = mask;
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    wait_ready();
    start_req = 1'b1;
    @(negedge clk);
    start_req = 1'b0;
    for (int i = 0; i < 1500 && got < n; i++) begin
      @(negedge clk);
      // A paced start is never refused
      chk({15'h0, start_refused}, 16'h0000);
      if (adc_seq_if_inst.busy === 1'b1) begin
        busy_cyc++;
        chk({12'h0, hold}, 16'h000F);
        chk({15'h0, ready}, 16'h0000);
      end
      if (result_valid === 1'b1) begin
        while (!mask[ch]) ch++;
        chk({4'h0, result}, {4'h0, sample_in[ch*12 +: 12]});
        chk({14'h0, result_chan}, {14'h0, ch});
        got++;
        ch++;
      end
    end
    chk(16'(got), 16'(n));
    chk(16'(busy_cyc), 16'(165 * n));
    chk({12'h0, sel_mask}, {12'h0, mask});
    // Track time still running just after the last word
    chk({15'h0, ready}, 16'h0000);
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Five sequences need well under 10000 cycles
  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 5; k++) begin
      sample_in = 48'hF0E1_D2C3_B4A5 + 48'(k);
      run_seq(tbl[k][4], tbl[k][3:0]);
    end
    end_sim();
  end
endmodule // simultaneous_sampling_adc_sequencer_tb
